// File: rtl/can_req_pkg.sv
// Behaviour
// - Masked stored message raises receive interrupt
// - Global enable low blocks all receive interrupts
// - Writing one sets request, zero ignored
// - Request transmits; cleared by hardware when done
// - Pending objects sent highest number first
// - Cancel write clears request unless in progress
// - Cancel bit zero leaves request unchanged
// - Cancel registers are write only
// - Remote pending set on remote, cleared after send
// - Stamp counter readable and writable byte-wise
// - Reception into objects 0-7 captures stamp
// - Object stamps 16-bit, read only, no reset
// - Ready flag set by store, cleared by zero
`default_nettype none
package can_req_pkg;

  localparam int NUM_OBJ       = 16;
  localparam int NUM_STAMP_OBJ = 8;
  localparam int STAMP_W       = 16;

  // Register offsets on the host port
  localparam logic [7:0] OFF_RX_READY_LOW        = 8'h04;
  localparam logic [7:0] OFF_RX_READY_HIGH       = 8'h05;
  localparam logic [7:0] OFF_RX_IRQ_MASK_LOW     = 8'h06;
  localparam logic [7:0] OFF_RX_IRQ_MASK_HIGH    = 8'h07;
  localparam logic [7:0] OFF_TX_REQUEST_SET_LOW  = 8'h08;
  localparam logic [7:0] OFF_TX_REQUEST_SET_HIGH = 8'h09;
  localparam logic [7:0] OFF_TX_CANCEL_LOW       = 8'h18;
  localparam logic [7:0] OFF_TX_CANCEL_HIGH      = 8'h19;
  localparam logic [7:0] OFF_REMOTE_PENDING_LOW  = 8'h1a;
  localparam logic [7:0] OFF_REMOTE_PENDING_HIGH = 8'h1b;
  localparam logic [7:0] OFF_STAMP_COUNTER_HIGH  = 8'h1c;
  localparam logic [7:0] OFF_STAMP_COUNTER_LOW   = 8'h1d;
  localparam logic [3:0] OFF_OBJECT_STAMP_PAGE   = 4'h3;

  // Values after reset
  localparam logic [15:0] RST_MASK      = 16'h0000;
  localparam logic [15:0] RST_FLAGS     = 16'h0000;
  localparam logic [15:0] RST_STAMP     = 16'h0000;
  localparam logic [7:0]  RD_NONE       = 8'h00;

  // Stamp counter tick rate
  localparam int CLK_PERIOD_NS      = 40;
  localparam int STAMP_TICK_NS      = 1000;
  localparam int STAMP_TICK_CYCLES  = (STAMP_TICK_NS / CLK_PERIOD_NS < 1) ? 1 :
                                      STAMP_TICK_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic       store;
    logic       remote;
    logic [3:0] obj;
  } rx_event_t;

endpackage : can_req_pkg
`default_nettype wire

// File: rtl/tx_priority_pick.sv
`timescale 1ns/1ns
`default_nettype none
module tx_priority_pick #(
  parameter int N = 16,
  parameter int W = 4
) (
  input  wire logic [N-1:0] i_pending,
  output logic              o_any,
  output logic [W-1:0]      o_obj
);

  // Later iterations overwrite, so the highest set bit wins
  always_comb begin
    o_any = 1'b0;
    o_obj = '0;
    for (int i = 0; i < N; i++) begin
      if (i_pending[i]) begin
        o_any = 1'b1;
        o_obj = W'(i);
      end
    end
  end

endmodule : tx_priority_pick
`default_nettype wire

// File: rtl/stamp_counter.sv
`timescale 1ns/1ns
`default_nettype none
module stamp_counter #(
  parameter int TICK_CYCLES = can_req_pkg::STAMP_TICK_CYCLES
) (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_wr_high,
  input  wire logic        i_wr_low,
  input  wire logic [7:0]  i_wdata,
  output logic      [15:0] o_count
);

  localparam int DW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  logic [DW-1:0] div_reg;
  logic [DW-1:0] div_next;
  logic [15:0]   count_reg;
  logic [15:0]   count_next;
  logic          tick;

  always_comb begin
    tick       = (div_reg == DW'(TICK_CYCLES - 1));
    div_next   = tick ? '0 : div_reg + 1'b1;
    count_next = count_reg;
    // Wrap from all ones is plain modulo arithmetic, no event
    if (tick) begin
      count_next = count_reg + 16'h0001;
    end
    // Host write overrides the tick for the written byte only; the other byte still takes the tick and its carry
    if (i_wr_high) begin
      count_next[15:8] = i_wdata;
    end
    if (i_wr_low) begin
      count_next[7:0] = i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      div_reg   <= '0;
      count_reg <= can_req_pkg::RST_STAMP;
    end else begin
      div_reg   <= div_next;
      count_reg <= count_next;
    end
  end

  assign o_count = count_reg;

endmodule : stamp_counter
`default_nettype wire

// File: rtl/can_msg_request_status_bank.sv
`timescale 1ns/1ns
`default_nettype none
module can_msg_request_status_bank #(
  parameter int STAMP_TICK = can_req_pkg::STAMP_TICK_CYCLES
) (
  input  wire logic       I_CLK_SYS,
  input  wire logic       I_NRST,
  input  wire logic       I_HOST_WR,
  input  wire logic       I_HOST_RD,
  input  wire logic [7:0] I_HOST_ADDR,
  input  wire logic [7:0] I_HOST_WDATA,
  output logic      [7:0] O_HOST_RDATA,
  output logic            O_HOST_RVALID,
  input  wire logic       I_GLOBAL_RX_IRQ_ENABLE,
  input  wire logic       I_RX_STORE,
  input  wire logic       I_RX_REMOTE,
  input  wire logic [3:0] I_RX_OBJ,
  input  wire logic       I_TX_DONE,
  output logic            O_TX_REQ,
  output logic      [3:0] O_TX_OBJ,
  output logic            O_RX_IRQ
);

  localparam int N = can_req_pkg::NUM_OBJ;

  can_req_pkg::host_req_t host;
  can_req_pkg::rx_event_t rx;

  assign host = '{wr: I_HOST_WR, rd: I_HOST_RD, addr: I_HOST_ADDR, wdata: I_HOST_WDATA};
  assign rx   = '{store: I_RX_STORE, remote: I_RX_REMOTE, obj: I_RX_OBJ};

  ////////////////////////////////////////////////////////////////////////////////
  // Write decode

  logic wr_mask_lo;
  logic wr_mask_hi;
  logic wr_set_lo;
  logic wr_set_hi;
  logic wr_cancel_lo;
  logic wr_cancel_hi;
  logic wr_ready_lo;
  logic wr_ready_hi;
  logic wr_stamp_hi;
  logic wr_stamp_lo;

  always_comb begin
    wr_mask_lo   = host.wr && host.addr == can_req_pkg::OFF_RX_IRQ_MASK_LOW;
    wr_mask_hi   = host.wr && host.addr == can_req_pkg::OFF_RX_IRQ_MASK_HIGH;
    wr_set_lo    = host.wr && host.addr == can_req_pkg::OFF_TX_REQUEST_SET_LOW;
    wr_set_hi    = host.wr && host.addr == can_req_pkg::OFF_TX_REQUEST_SET_HIGH;
    wr_cancel_lo = host.wr && host.addr == can_req_pkg::OFF_TX_CANCEL_LOW;
    wr_cancel_hi = host.wr && host.addr == can_req_pkg::OFF_TX_CANCEL_HIGH;
    wr_ready_lo  = host.wr && host.addr == can_req_pkg::OFF_RX_READY_LOW;
    wr_ready_hi  = host.wr && host.addr == can_req_pkg::OFF_RX_READY_HIGH;
    wr_stamp_hi  = host.wr && host.addr == can_req_pkg::OFF_STAMP_COUNTER_HIGH;
    wr_stamp_lo  = host.wr && host.addr == can_req_pkg::OFF_STAMP_COUNTER_LOW;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-object bit vectors from writes and events

  logic [N-1:0] set_bits;
  logic [N-1:0] cancel_bits;
  logic [N-1:0] ready_keep;
  logic [N-1:0] store_hit;
  logic [N-1:0] remote_hit;
  logic [N-1:0] done_hit;
  logic [N-1:0] busy_hit;

  logic [N-1:0] rx_mask_reg;
  logic [N-1:0] rx_mask_next;
  logic [N-1:0] rx_ready_reg;
  logic [N-1:0] rx_ready_next;
  logic [N-1:0] tx_req_reg;
  logic [N-1:0] tx_req_next;
  logic [N-1:0] remote_reg;
  logic [N-1:0] remote_next;
  logic         tx_busy_reg;
  logic         tx_busy_next;
  logic [3:0]   tx_obj_reg;
  logic [3:0]   tx_obj_next;
  logic         irq_reg;
  logic         irq_next;

  always_comb begin
    // Only bits written as ones in a written byte take effect
    set_bits    = {wr_set_hi ? host.wdata : 8'h00,
                   wr_set_lo ? host.wdata : 8'h00};
    cancel_bits = {wr_cancel_hi ? host.wdata : 8'h00,
                   wr_cancel_lo ? host.wdata : 8'h00};
    // Ready flags: a zero written clears, a one keeps
    ready_keep  = {wr_ready_hi ? host.wdata : 8'hff,
                   wr_ready_lo ? host.wdata : 8'hff};
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-object event decode

  // One slice per message object; each slice drives one bit of every hit vector
  for (genvar g = 0; g < N; g++) begin : g_obj
    logic rx_sel;
    logic tx_sel;

    assign rx_sel        = (rx.obj == 4'(g));
    assign tx_sel        = tx_busy_reg && (tx_obj_reg == 4'(g));
    assign store_hit[g]  = rx.store && rx_sel;
    assign remote_hit[g] = rx.remote && rx_sel;
    assign busy_hit[g]   = tx_sel;
    assign done_hit[g]   = tx_sel && I_TX_DONE;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit scheduling

  logic         pick_any;
  logic [3:0]   pick_obj;
  logic [N-1:0] pick_pool;

  // Objects cancelled this cycle must not be picked
  assign pick_pool = tx_req_reg & ~cancel_bits & ~done_hit;

  tx_priority_pick #(
    .N (N),
    .W (4)
  ) u_pick (
    .i_pending (pick_pool),
    .o_any     (pick_any),
    .o_obj     (pick_obj)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Receive interrupt mask

  always_comb begin
    rx_mask_next = rx_mask_reg;
    if (wr_mask_lo) begin
      rx_mask_next[7:0] = host.wdata;
    end
    if (wr_mask_hi) begin
      rx_mask_next[15:8] = host.wdata;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      rx_mask_reg <= can_req_pkg::RST_MASK;
    end else begin
      rx_mask_reg <= rx_mask_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive ready flags and interrupt

  always_comb begin
    // Store sets after the host clear, so an arrival is never lost
    rx_ready_next = (rx_ready_reg & ready_keep) | store_hit;
    irq_next      = rx.store && rx_mask_reg[rx.obj] && I_GLOBAL_RX_IRQ_ENABLE;
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      rx_ready_reg <= can_req_pkg::RST_FLAGS;
      irq_reg      <= 1'b0;
    end else begin
      rx_ready_reg <= rx_ready_next;
      irq_reg      <= irq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit requests and remote pending flags

  always_comb begin
    // Cancel spares the object in flight; host set wins over every clear
    tx_req_next = tx_req_reg & ~(cancel_bits & ~busy_hit);
    tx_req_next = tx_req_next & ~done_hit;
    tx_req_next = tx_req_next | set_bits;
    // Remote pending ends with the data frame sent for that object
    remote_next = (remote_reg & ~done_hit) | remote_hit;
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      tx_req_reg <= can_req_pkg::RST_FLAGS;
      remote_reg <= can_req_pkg::RST_FLAGS;
    end else begin
      tx_req_reg <= tx_req_next;
      remote_reg <= remote_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit engine handshake

  always_comb begin
    tx_busy_next = tx_busy_reg;
    tx_obj_next  = tx_obj_reg;
    // A done pulse while idle is ignored
    if (tx_busy_reg) begin
      if (I_TX_DONE) begin
        tx_busy_next = 1'b0;
      end
    end else if (pick_any) begin
      // One transmission at a time, highest pending first
      tx_busy_next = 1'b1;
      tx_obj_next  = pick_obj;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      tx_busy_reg <= 1'b0;
      tx_obj_reg  <= 4'h0;
    end else begin
      tx_busy_reg <= tx_busy_next;
      tx_obj_reg  <= tx_obj_next;
    end
  end

  assign O_TX_REQ = tx_busy_reg;
  assign O_TX_OBJ = tx_obj_reg;
  assign O_RX_IRQ = irq_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Time stamps

  logic [15:0] stamp_now;

  stamp_counter #(
    .TICK_CYCLES (STAMP_TICK)
  ) u_stamp (
    .i_clk     (I_CLK_SYS),
    .i_nrst    (I_NRST),
    .i_wr_high (wr_stamp_hi),
    .i_wr_low  (wr_stamp_lo),
    .i_wdata   (host.wdata),
    .o_count   (stamp_now)
  );

  // No reset on purpose: contents are undefined until first capture
  logic [15:0] obj_stamp_mem [can_req_pkg::NUM_STAMP_OBJ];
  logic        cap_en;

  assign cap_en = rx.store && (rx.obj < 4'(can_req_pkg::NUM_STAMP_OBJ));

  always_ff @(posedge I_CLK_SYS) begin
    if (cap_en) begin
      obj_stamp_mem[rx.obj[2:0]] <= stamp_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path, one cycle latency

  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  logic        rvalid_reg;
  logic        rvalid_next;
  logic [15:0] stamp_sel;

  assign stamp_sel = obj_stamp_mem[host.addr[3:1]];

  always_comb begin
    rvalid_next = host.rd;
    rdata_next  = rdata_reg;
    if (host.rd) begin
      unique case (host.addr)
        can_req_pkg::OFF_RX_READY_LOW:        rdata_next = rx_ready_reg[7:0];
        can_req_pkg::OFF_RX_READY_HIGH:       rdata_next = rx_ready_reg[15:8];
        can_req_pkg::OFF_RX_IRQ_MASK_LOW:     rdata_next = rx_mask_reg[7:0];
        can_req_pkg::OFF_RX_IRQ_MASK_HIGH:    rdata_next = rx_mask_reg[15:8];
        can_req_pkg::OFF_TX_REQUEST_SET_LOW:  rdata_next = tx_req_reg[7:0];
        can_req_pkg::OFF_TX_REQUEST_SET_HIGH: rdata_next = tx_req_reg[15:8];
        can_req_pkg::OFF_REMOTE_PENDING_LOW:  rdata_next = remote_reg[7:0];
        can_req_pkg::OFF_REMOTE_PENDING_HIGH: rdata_next = remote_reg[15:8];
        can_req_pkg::OFF_STAMP_COUNTER_HIGH:  rdata_next = stamp_now[15:8];
        can_req_pkg::OFF_STAMP_COUNTER_LOW:   rdata_next = stamp_now[7:0];
        default: begin
          // Cancel registers fall here and read as zero
          rdata_next = can_req_pkg::RD_NONE;
          if (host.addr[7:4] == can_req_pkg::OFF_OBJECT_STAMP_PAGE) begin
            rdata_next = host.addr[0] ? stamp_sel[7:0] : stamp_sel[15:8];
          end
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      rdata_reg  <= can_req_pkg::RD_NONE;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign O_HOST_RDATA  = rdata_reg;
  assign O_HOST_RVALID = rvalid_reg;

endmodule : can_msg_request_status_bank
`default_nettype wire

// File: sim/can_msg_request_status_bank_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module can_msg_request_status_bank_monitor #(
  parameter int STAMP_TICK = 2
) (
  input wire logic       I_CLK_SYS,
  input wire logic       I_NRST,
  input wire logic       I_HOST_WR,
  input wire logic       I_HOST_RD,
  input wire logic [7:0] I_HOST_ADDR,
  input wire logic [7:0] I_HOST_WDATA,
  input wire logic [7:0] O_HOST_RDATA,
  input wire logic       O_HOST_RVALID,
  input wire logic       I_GLOBAL_RX_IRQ_ENABLE,
  input wire logic       I_RX_STORE,
  input wire logic       I_RX_REMOTE,
  input wire logic [3:0] I_RX_OBJ,
  input wire logic       I_TX_DONE,
  input wire logic       O_TX_REQ,
  input wire logic [3:0] O_TX_OBJ,
  input wire logic       O_RX_IRQ
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_NRST);
  ////////////////////////////////////////////////////////////////
  sequence s_done; O_TX_REQ && I_TX_DONE; endsequence
  sequence s_idle; !O_TX_REQ; endsequence
  property p_irq_cause; O_RX_IRQ |-> $past(I_RX_STORE) && $past(I_GLOBAL_RX_IRQ_ENABLE); endproperty
  property p_irq_off; !I_GLOBAL_RX_IRQ_ENABLE |=> !O_RX_IRQ; endproperty
  property p_no_store; !I_RX_STORE |=> !O_RX_IRQ; endproperty
  property p_rvalid; I_HOST_RD |=> O_HOST_RVALID ##1 (!O_HOST_RVALID || $past(I_HOST_RD)); endproperty
  property p_cancel_ro; I_HOST_RD && I_HOST_ADDR[7:1] == 7'h0c |=> O_HOST_RDATA == 8'h00; endproperty
  property p_done; s_done |=> s_idle; endproperty
  property p_hold; O_TX_REQ && !I_TX_DONE |=> O_TX_REQ && $stable(O_TX_OBJ); endproperty
  property p_rdata_hold; !I_HOST_RD |=> $stable(O_HOST_RDATA) && !O_HOST_RVALID; endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without enabled store");
  a_irq_off: assert property (p_irq_off) else $error("irq while globally disabled");
  a_no_store: assert property (p_no_store) else $error("irq without store");
  a_rvalid: assert property (p_rvalid) else $error("read answer timing");
  a_cancel_ro: assert property (p_cancel_ro) else $error("cancel register readable");
  a_done: assert property (p_done) else $error("request kept after done");
  a_hold: assert property (p_hold) else $error("transfer dropped early");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
endmodule : can_msg_request_status_bank_monitor
`default_nettype wire

// File: sim/tx_engine_model.sv
`timescale 1ns/1ns
`default_nettype none
module tx_engine_model (
  input  wire logic       i_clk,
  input  wire logic       i_req,
  input  wire logic [3:0] i_obj,
  input  wire logic [7:0] i_delay,
  output logic            o_done
);
  int         cnt = 0;
  logic [3:0] sent[$];
  initial o_done = 1'b0;
  // Frame takes i_delay cycles; done is a one-cycle pulse
  always @(negedge i_clk) begin
    o_done <= 1'b0;
    if (!i_req) cnt = 0;
    else if (!o_done) begin
      cnt++;
      if (cnt >= i_delay) begin
        o_done <= 1'b1;
        sent.push_back(i_obj);
        cnt = 0;
      end
    end
  end
endmodule : tx_engine_model
`default_nettype wire

// File: sim/can_msg_request_status_bank_test.sv
`timescale 1ns/1ns
`default_nettype none
module can_msg_request_status_bank_test;
  logic        clk = 1'b0;
  logic        nrst, wr, rd, en, store, remote, rvalid, tx_req, irq, done;
  logic [7:0]  addr, wdata, rdata, v, s, dly;
  logic [3:0]  obj, tx_obj;
  logic [15:0] m;
  int          fails = 0, n_compared = 0, seed = 83;
  logic [7:0]  rst_map[10] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h18, 8'h19,
                               8'h1a, 8'h00};
  always #20 clk = ~clk;
  can_msg_request_status_bank #(.STAMP_TICK(2)) uut (.I_CLK_SYS(clk), .I_NRST(nrst),
    .I_HOST_WR(wr), .I_HOST_RD(rd), .I_HOST_ADDR(addr), .I_HOST_WDATA(wdata),
    .O_HOST_RDATA(rdata), .O_HOST_RVALID(rvalid), .I_GLOBAL_RX_IRQ_ENABLE(en),
    .I_RX_STORE(store), .I_RX_REMOTE(remote), .I_RX_OBJ(obj), .I_TX_DONE(done),
    .O_TX_REQ(tx_req), .O_TX_OBJ(tx_obj), .O_RX_IRQ(irq));
  tx_engine_model partner (.i_clk(clk), .i_req(tx_req), .i_obj(tx_obj), .i_delay(dly),
    .o_done(done));
  ////////////////////////////////////////////////////////////////
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check8
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk); wr = 1'b1; addr = a; wdata = d;
    @(negedge clk); wr = 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk); rd = 1'b1; addr = a;
    @(negedge clk); rd = 1'b0;
    check8(rdata, exp);
  endtask : rd_chk
  task automatic rx_ev(input logic st, input logic rm, input logic [3:0] o);
    @(negedge clk); store = st; remote = rm; obj = o;
    @(negedge clk); store = 1'b0; remote = 1'b0;
  endtask : rx_ev
  task automatic wait_sent(input int n);
    for (int i = 0; i < 400 && partner.sent.size() < n; i++) @(negedge clk);
  endtask : wait_sent
  function automatic logic [3:0] top_obj(input logic [15:0] p);
    top_obj = 4'h0;
    for (int i = 0; i < 16; i++) if (p[i]) top_obj = i[3:0];
  endfunction : top_obj
  task automatic tend(input string n);
    $display("test %s finished", n);
  endtask : tend
  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////
  initial begin : watchdog
    #400000;
    fails++;
    stop_test();
  end
  initial begin
    {nrst, wr, rd, en, store, remote} = 6'h00;
    addr = 8'h00; wdata = 8'h00; obj = 4'h0; dly = 8'h02;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    foreach (rst_map[i]) rd_chk(rst_map[i], 8'h00);
    tend("reset");
    v = 8'($random(seed));
    wr_reg(8'h07, v);
    rd_chk(8'h07, v);
    for (int k = 0; k < 4; k++) begin
      en = k[1];
      wr_reg(8'h06, k[0] ? 8'h08 : 8'hf7);
      rx_ev(1'b1, 1'b0, 4'h3);
      check8({7'h00, irq}, {7'h00, k[0] & k[1]});
    end
    rx_ev(1'b1, 1'b0, 4'hc);
    check8({7'h00, irq}, {7'h00, v[4]});
    rd_chk(8'h04, 8'h08);
    wr_reg(8'h04, 8'hff);
    rd_chk(8'h04, 8'h08);
    wr_reg(8'h04, 8'h00);
    rd_chk(8'h04, 8'h00);
    tend("irq");
    v = 8'($random(seed));
    s = 8'($random(seed));
    m = {v | 8'h80, s};
    wr_reg(8'h09, m[15:8]);
    wr_reg(8'h08, m[7:0]);
    wait_sent($countones(m));
    for (int i = 0; m != 16'h0000; i++) begin
      check8({4'h0, partner.sent[i]}, {4'h0, top_obj(m)});
      m[top_obj(m)] = 1'b0;
    end
    rd_chk(8'h08, 8'h00);
    rd_chk(8'h09, 8'h00);
    tend("order");
    // Slow frame so the cancel lands while object 7 is on the wire
    dly = 8'd20;
    partner.sent.delete();
    wr_reg(8'h08, 8'hff);
    repeat (2) @(negedge clk);
    wr_reg(8'h18, 8'hfe);
    rd_chk(8'h08, 8'h81);
    wr_reg(8'h08, 8'h00);
    rd_chk(8'h08, 8'h81);
    wait_sent(2);
    check8({4'h0, partner.sent[0]}, 8'h07);
    check8({4'h0, partner.sent[1]}, 8'h00);
    tend("cancel");
    dly = 8'd3;
    partner.sent.delete();
    rx_ev(1'b0, 1'b1, 4'h4);
    rd_chk(8'h1a, 8'h10);
    wr_reg(8'h08, 8'h10);
    wait_sent(1);
    rd_chk(8'h1a, 8'h00);
    tend("remote");
    // Low byte first, so no tick carries into the high byte before it is written
    wr_reg(8'h1d, 8'hfc);
    wr_reg(8'h1c, 8'hff);
    rd_chk(8'h1c, 8'hff);
    repeat (10) @(negedge clk);
    rd_chk(8'h1c, 8'h00);
    @(negedge clk); store = 1'b1; obj = 4'h2; rd = 1'b1; addr = 8'h1d;
    @(negedge clk); store = 1'b0; rd = 1'b0;
    v = rdata;
    rd_chk(8'h35, v);
    wr_reg(8'h35, ~v);
    rd_chk(8'h35, v);
    rd_chk(8'h34, 8'h00);
    tend("stamp");
    stop_test();
  end
endmodule : can_msg_request_status_bank_test
bind can_msg_request_status_bank can_msg_request_status_bank_monitor #(.STAMP_TICK(STAMP_TICK))
  mon (.I_CLK_SYS(I_CLK_SYS), .I_NRST(I_NRST), .I_HOST_WR(I_HOST_WR), .I_HOST_RD(I_HOST_RD),
  .I_HOST_ADDR(I_HOST_ADDR), .I_HOST_WDATA(I_HOST_WDATA), .O_HOST_RDATA(O_HOST_RDATA),
  .O_HOST_RVALID(O_HOST_RVALID), .I_GLOBAL_RX_IRQ_ENABLE(I_GLOBAL_RX_IRQ_ENABLE),
  .I_RX_STORE(I_RX_STORE), .I_RX_REMOTE(I_RX_REMOTE), .I_RX_OBJ(I_RX_OBJ),
  .I_TX_DONE(I_TX_DONE), .O_TX_REQ(O_TX_REQ), .O_TX_OBJ(O_TX_OBJ), .O_RX_IRQ(O_RX_IRQ));
`default_nettype wire
